/* File: design/csi_pkg.sv */
// Package for the CAN status and interrupt flag block.
// Assumes a classic Wishbone slave with 32-bit data, one register per word.
package csi_pkg;

  // Register indices (byte address is index times four)
  localparam logic [7:0] CSI_IDX_MODE      = 8'h00; // Reset request, sleep
  localparam logic [7:0] CSI_IDX_CMD       = 8'h01; // Command strobes
  localparam logic [7:0] CSI_IDX_STATUS    = 8'h02; // Status flags
  localparam logic [7:0] CSI_IDX_IRQ       = 8'h03; // Interrupt flags
  localparam logic [7:0] CSI_IDX_ENABLE    = 8'h04; // Interrupt enables
  localparam logic [7:0] CSI_IDX_RXLEVEL   = 8'h05; // Receive level
  localparam logic [7:0] CSI_IDX_ARBCAP    = 8'h0B; // Arbitration capture
  localparam logic [7:0] CSI_IDX_ERRCAP    = 8'h0C; // Error code capture
  localparam logic [7:0] CSI_IDX_RXERR     = 8'h0E; // Receive error counter
  localparam logic [7:0] CSI_IDX_TXERR     = 8'h0F; // Transmit error counter

  // Interrupt flag bit positions
  localparam int CSI_IRQ_RX   = 0;
  localparam int CSI_IRQ_TX   = 1;
  localparam int CSI_IRQ_ERR  = 2;
  localparam int CSI_IRQ_OVR  = 3;
  localparam int CSI_IRQ_WAKE = 4;
  localparam int CSI_IRQ_EPAS = 5;
  localparam int CSI_IRQ_ARB  = 6;
  localparam int CSI_IRQ_BERR = 7;

  // Command bit positions
  localparam int CSI_CMD_TXREQ  = 0;
  localparam int CSI_CMD_RELEASE = 2;
  localparam int CSI_CMD_CLROVR = 3;
  localparam int CSI_CMD_SELFRX = 4;

  // Mode bit positions
  localparam int CSI_MODE_RESET = 0;
  localparam int CSI_MODE_SLEEP = 4;

  // Limits and reset values
  localparam logic [8:0] CSI_TXERR_LIMIT   = 9'h0FF; // Bus-off beyond this
  localparam logic [7:0] CSI_TXERR_BUSOFF  = 8'h7F;  // Load on bus-off
  localparam logic [7:0] CSI_WARN_LIMIT    = 8'h60;  // Warning at or above
  localparam logic [7:0] CSI_PASSIVE_LIMIT = 8'h7F;  // Passive above
  localparam logic [7:0] CSI_RECOVERY_CNT  = 8'h80;  // Bus-free count
  localparam logic [7:0] CSI_MODE_RST_VAL  = 8'h01;  // Reset mode after reset
  localparam logic [7:0] CSI_ZERO8         = 8'h00;

  // Recovery state
  typedef enum logic [1:0] {CSI_ON, CSI_OFF_HOLD, CSI_OFF_RECOVER} csi_bus_state_t;

  // Events from the protocol engine
  typedef struct packed {
    logic       tx_err_inc;   // Transmit error counter up by 8
    logic       rx_err_inc;   // Receive error counter up by 1
    logic       tx_ok;        // Frame sent successfully
    logic       rx_ok;        // Frame stored successfully
    logic       bus_error;    // Bus error detected
    logic       arb_lost;     // Arbitration lost
    logic       bus_free;     // Bus-free condition seen
    logic       bus_activity; // Any bus activity
    logic       transmitting; // Engine transmitting
    logic       receiving;    // Engine receiving
    logic       frame_valid;  // Accepted frame became valid
    logic       frame_no_room;// That frame lacked FIFO room
    logic       high_prio;    // Frame passed high-priority filter
  } csi_engine_t;

  // FIFO state
  typedef struct packed {
    logic [7:0] byte_count;   // Valid message bytes
    logic [5:0] msg_count;    // Complete messages held
  } csi_fifo_t;

endpackage

/* File: design/csi_status_irq.sv */
// CAN status flags, error counters, bus-off recovery and interrupt flags.
// Assumes a classic Wishbone master and a protocol engine on clk_i.
//
// Function
// - Transmit counter past 255: bus-off, reset mode
// - Bus-off loads transmit counter with 127
// - Stay in reset until CPU clears it
// - Count down over 128 bus-free conditions
// - Recovery end clears bus-off flag and counters, raises error interrupt
// - Transmit counter readable during recovery
// - Warning flag when a counter reaches 96
// - Bus idle when neither receiving nor transmitting
// - Transmit request clears complete flag until success
// - Locked transmit buffer drops writes silently
// - Overrun flagged when roomless frame becomes valid
// - Buffer-full clears once all messages released
// - Interrupt output high while any flag set
// - Flag register read clears all but receive
// - Bus error flag locked until capture read
// - Arbitration flag locked until capture read
// - Passive flag on entering or leaving passive
// - Wake-up flag on activity while sleeping
// - Overrun interrupt on rising overrun status
// - Error interrupt on warning or bus-off change
// - Transmit interrupt on buffer released rising
// - Receive interrupt on level or priority
// - Release clears receive flag, re-set if qualifying
`timescale 1ns/1ps
module csi_status_irq (
  input  wire logic                 clk_i,        // 40 MHz system clock
  input  wire logic                 rst_i,        // Synchronous reset
  input  wire logic                 wb_cyc_i,     // Wishbone cycle
  input  wire logic                 wb_stb_i,     // Wishbone strobe
  input  wire logic                 wb_we_i,      // Write enable
  input  wire logic [7:0]           wb_adr_i,     // Byte address
  input  wire logic [3:0]           wb_sel_i,     // Byte lanes
  input  wire logic [31:0]          wb_dat_i,     // Write data
  output logic      [31:0]          wb_dat_o,     // Read data
  output logic                      wb_ack_o,     // Acknowledge
  input  wire csi_pkg::csi_engine_t eng_i,        // Engine events
  input  wire csi_pkg::csi_fifo_t   fifo_i,       // FIFO state
  input  wire logic                 txbuf_wr_i,   // CPU write to transmit buffer
  output logic                      txbuf_we_o,   // Accepted buffer write
  output logic                      tx_start_o,   // Transmit request pulse
  output logic                      rx_release_o, // Release command pulse
  output logic                      reset_mode_o, // Reset mode active
  output logic                      bus_idle_o,   // Bus idle
  output logic                      irq_o         // Interrupt request
);
  import csi_pkg::*;

  // Registers
  logic [7:0]     mode;             // Mode bits
  logic [7:0]     irq_enable;       // Interrupt enables
  logic [7:0]     rx_level;         // Receive level
  logic [7:0]     interrupt_flags;  // Interrupt flags
  logic [7:0]     tx_err;           // Transmit error counter
  logic [7:0]     rx_err;           // Receive error counter
  logic [7:0]     bus_free_cnt;     // Recovery count
  csi_bus_state_t bus_state;        // Bus-off state
  logic           bus_off_flag;
  logic           error_warning_flag;
  logic           tx_complete_flag;
  logic           tx_buffer_released_flag;
  logic           tx_pending;       // Request waiting or running
  logic           data_overrun_status;
  logic           err_passive;      // Passive state
  logic           berr_locked;      // Bus error lock
  logic           arb_locked;       // Arbitration lock
  // Previous values for edge detection
  logic           prev_bus_off, prev_warn, prev_ovr, prev_tbr, prev_passive;

  // Bus access decode
  logic           acc, wr, rd;
  logic [7:0]     wbyte;
  logic           cmd_tx, cmd_rel, cmd_clrovr;
  logic [8:0]     tx_sum;
  logic           enter_bus_off;
  logic           rx_qualify;
  logic           next_warn;
  logic           next_passive;

  always_comb begin
    acc        = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wr         = acc && wb_we_i && wb_sel_i[0];
    rd         = acc && !wb_we_i;
    wbyte      = wb_dat_i[7:0];
    cmd_tx     = wr && (wb_adr_i == {CSI_IDX_CMD[5:0], 2'b00}) &&
                 (wbyte[CSI_CMD_TXREQ] || wbyte[CSI_CMD_SELFRX]);
    cmd_rel    = wr && (wb_adr_i == {CSI_IDX_CMD[5:0], 2'b00}) && wbyte[CSI_CMD_RELEASE];
    cmd_clrovr = wr && (wb_adr_i == {CSI_IDX_CMD[5:0], 2'b00}) && wbyte[CSI_CMD_CLROVR];
    tx_sum     = {1'b0, tx_err} + 9'h008;
    enter_bus_off = (bus_state == CSI_ON) && eng_i.tx_err_inc && (tx_sum > CSI_TXERR_LIMIT);
    rx_qualify = (fifo_i.msg_count != 6'h00) && (fifo_i.byte_count > rx_level);
    next_warn  = (tx_err >= CSI_WARN_LIMIT) || (rx_err >= CSI_WARN_LIMIT);
    next_passive = (tx_err > CSI_PASSIVE_LIMIT) || (rx_err > CSI_PASSIVE_LIMIT);
  end

  // Wishbone acknowledge, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  // Read data mux
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      case (wb_adr_i)
        {CSI_IDX_MODE[5:0], 2'b00}:    wb_dat_o <= {24'h000000, mode};
        {CSI_IDX_STATUS[5:0], 2'b00}: begin
          wb_dat_o <= {24'h000000, bus_off_flag, error_warning_flag, eng_i.transmitting,
                       eng_i.receiving, tx_complete_flag, tx_buffer_released_flag,
                       data_overrun_status, fifo_i.msg_count != 6'h00};
        end
        {CSI_IDX_IRQ[5:0], 2'b00}:     wb_dat_o <= {24'h000000, interrupt_flags};
        {CSI_IDX_ENABLE[5:0], 2'b00}:  wb_dat_o <= {24'h000000, irq_enable};
        {CSI_IDX_RXLEVEL[5:0], 2'b00}: wb_dat_o <= {24'h000000, rx_level};
        {CSI_IDX_RXERR[5:0], 2'b00}:   wb_dat_o <= {24'h000000, rx_err};
        {CSI_IDX_TXERR[5:0], 2'b00}:   wb_dat_o <= {24'h000000, tx_err};
        default:                       wb_dat_o <= 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // Control registers: mode, enables, receive level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode       <= CSI_MODE_RST_VAL;
      irq_enable <= CSI_ZERO8;
      rx_level   <= CSI_ZERO8;
    end else begin
      if (wr && wb_adr_i == {CSI_IDX_MODE[5:0], 2'b00}) begin
        mode <= wbyte;
      end
      if (enter_bus_off) begin
        mode[CSI_MODE_RESET] <= 1'b1;
      end
      if (wr && wb_adr_i == {CSI_IDX_ENABLE[5:0], 2'b00}) begin
        irq_enable <= wbyte;
      end
      if (wr && wb_adr_i == {CSI_IDX_RXLEVEL[5:0], 2'b00}) begin
        rx_level <= wbyte;
      end
    end
  end

  // Error counters and bus-off recovery
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_err       <= CSI_ZERO8;
      rx_err       <= CSI_ZERO8;
      bus_state    <= CSI_ON;
      bus_off_flag <= 1'b0;
      bus_free_cnt <= CSI_ZERO8;
    end else begin
      case (bus_state)
        CSI_ON: begin
          if (enter_bus_off) begin
            bus_off_flag <= 1'b1;
            tx_err    <= CSI_TXERR_BUSOFF;
            bus_state <= CSI_OFF_HOLD;
          end else begin
            if (eng_i.tx_err_inc) begin
              tx_err <= tx_sum[7:0];
            end else if (eng_i.tx_ok && tx_err != CSI_ZERO8) begin
              tx_err <= tx_err - 8'h01;
            end
            if (eng_i.rx_err_inc && rx_err != 8'hFF) begin
              rx_err <= rx_err + 8'h01;
            end else if (eng_i.rx_ok && rx_err != CSI_ZERO8) begin
              rx_err <= rx_err - 8'h01;
            end
          end
        end
        CSI_OFF_HOLD: begin
          if (!mode[CSI_MODE_RESET]) begin
            bus_free_cnt <= CSI_RECOVERY_CNT;
            bus_state    <= CSI_OFF_RECOVER;
          end
        end
        CSI_OFF_RECOVER: begin
          if (eng_i.bus_free) begin
            if (bus_free_cnt == 8'h01) begin
              bus_off_flag <= 1'b0;
              tx_err       <= CSI_ZERO8;
              rx_err       <= CSI_ZERO8;
              bus_state    <= CSI_ON;
            end else if (tx_err != CSI_ZERO8) begin
              tx_err <= tx_err - 8'h01;
            end
            bus_free_cnt <= bus_free_cnt - 8'h01;
          end
        end
        default: bus_state <= CSI_ON;
      endcase
    end
  end

  // Warning and passive status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error_warning_flag <= 1'b0;
      err_passive        <= 1'b0;
    end else begin
      // Counters zero at recovery end clear it
      error_warning_flag <= next_warn;
      err_passive        <= next_passive;
    end
  end

  // Transmit status and buffer lock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_complete_flag        <= 1'b0;
      tx_buffer_released_flag <= 1'b1;
      tx_pending              <= 1'b0;
      tx_start_o              <= 1'b0;
      txbuf_we_o              <= 1'b0;
    end else begin
      tx_start_o <= cmd_tx && tx_buffer_released_flag;
      txbuf_we_o <= txbuf_wr_i && tx_buffer_released_flag;
      if (cmd_tx && tx_buffer_released_flag) begin
        tx_complete_flag        <= 1'b0;
        tx_buffer_released_flag <= 1'b0;
        tx_pending              <= 1'b1;
      end else if (tx_pending && eng_i.tx_ok) begin
        tx_complete_flag        <= 1'b1;
        tx_buffer_released_flag <= 1'b1;
        tx_pending              <= 1'b0;
      end else if (bus_state != CSI_ON) begin
        tx_buffer_released_flag <= 1'b1;
        tx_pending              <= 1'b0;
      end
    end
  end

  // Overrun status and release pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_overrun_status <= 1'b0;
      rx_release_o        <= 1'b0;
    end else begin
      rx_release_o <= cmd_rel;
      if (eng_i.frame_valid && eng_i.frame_no_room) begin
        data_overrun_status <= 1'b1;
      end else if (cmd_clrovr) begin
        data_overrun_status <= 1'b0;
      end
    end
  end

  // Capture-register locks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      berr_locked <= 1'b0;
      arb_locked  <= 1'b0;
    end else begin
      if ((eng_i.bus_error || enter_bus_off) && irq_enable[CSI_IRQ_BERR]) begin
        berr_locked <= 1'b1;
      end else if (rd && wb_adr_i == {CSI_IDX_ERRCAP[5:0], 2'b00}) begin
        berr_locked <= 1'b0;
      end
      if (eng_i.arb_lost && irq_enable[CSI_IRQ_ARB]) begin
        arb_locked <= 1'b1;
      end else if (rd && wb_adr_i == {CSI_IDX_ARBCAP[5:0], 2'b00}) begin
        arb_locked <= 1'b0;
      end
    end
  end

  // Edge detection history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_bus_off <= 1'b0;
      prev_warn    <= 1'b0;
      prev_ovr     <= 1'b0;
      prev_tbr     <= 1'b1;
      prev_passive <= 1'b0;
    end else begin
      prev_bus_off <= bus_off_flag;
      prev_warn    <= error_warning_flag;
      prev_ovr     <= data_overrun_status;
      prev_tbr     <= tx_buffer_released_flag;
      prev_passive <= err_passive;
    end
  end

  // Interrupt flags: sets win over read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_flags <= CSI_ZERO8;
    end else begin
      if (rd && wb_adr_i == {CSI_IDX_IRQ[5:0], 2'b00}) begin
        interrupt_flags[7:1] <= 7'h00;
      end
      if ((eng_i.bus_error || enter_bus_off) && irq_enable[CSI_IRQ_BERR] && !berr_locked) begin
        interrupt_flags[CSI_IRQ_BERR] <= 1'b1;
      end
      if (eng_i.arb_lost && irq_enable[CSI_IRQ_ARB] && !arb_locked) begin
        interrupt_flags[CSI_IRQ_ARB] <= 1'b1;
      end
      if ((err_passive != prev_passive) && irq_enable[CSI_IRQ_EPAS]) begin
        interrupt_flags[CSI_IRQ_EPAS] <= 1'b1;
      end
      if (mode[CSI_MODE_SLEEP] && eng_i.bus_activity && irq_enable[CSI_IRQ_WAKE]) begin
        interrupt_flags[CSI_IRQ_WAKE] <= 1'b1;
      end
      if (data_overrun_status && !prev_ovr && irq_enable[CSI_IRQ_OVR]) begin
        interrupt_flags[CSI_IRQ_OVR] <= 1'b1;
      end
      if (((bus_off_flag != prev_bus_off) || (error_warning_flag != prev_warn)) &&
          irq_enable[CSI_IRQ_ERR]) begin
        interrupt_flags[CSI_IRQ_ERR] <= 1'b1;
      end
      if (tx_buffer_released_flag && !prev_tbr && irq_enable[CSI_IRQ_TX]) begin
        interrupt_flags[CSI_IRQ_TX] <= 1'b1;
      end
      if (cmd_rel) begin
        interrupt_flags[CSI_IRQ_RX] <= 1'b0;
      end else if (irq_enable[CSI_IRQ_RX] &&
                   (rx_qualify || (eng_i.frame_valid && eng_i.high_prio && !eng_i.frame_no_room))) begin
        interrupt_flags[CSI_IRQ_RX] <= 1'b1;
      end else if (fifo_i.msg_count == 6'h00) begin
        interrupt_flags[CSI_IRQ_RX] <= 1'b0;
      end
    end
  end

  // Output registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o        <= 1'b0;
      reset_mode_o <= 1'b1;
      bus_idle_o   <= 1'b1;
    end else begin
      irq_o        <= |interrupt_flags;
      reset_mode_o <= mode[CSI_MODE_RESET] || enter_bus_off;
      bus_idle_o   <= !eng_i.receiving && !eng_i.transmitting;
    end
  end

endmodule

/* File: dv/csi_status_irq_properties.sv */
// Checker for the CAN status and interrupt flag block, bound to its ports.
// Assumes one master that drops its strobe for a cycle after each ack.
`timescale 1ns/1ps
module csi_status_irq_properties (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [7:0]           wb_adr_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire csi_pkg::csi_engine_t eng_i,
  input wire logic                 txbuf_wr_i,
  input wire logic                 txbuf_we_o,
  input wire logic                 tx_start_o,
  input wire logic                 rx_release_o,
  input wire logic                 reset_mode_o,
  input wire logic                 bus_idle_o,
  input wire logic                 irq_o
);
  import csi_pkg::*;
  logic take;   // Write taken this edge
  logic cmd_tx; // Transmit or self-receive command
  logic cmd_rl; // Release command
  logic mode_0; // Reset request cleared
  assign take   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign cmd_tx = take & (wb_adr_i == 8'h04) & (wb_dat_i[0] | wb_dat_i[4]);
  assign cmd_rl = take & (wb_adr_i == 8'h04) & wb_dat_i[2];
  assign mode_0 = take & (wb_adr_i == 8'h00) & ~wb_dat_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_reset; disable iff (1'b0) rst_i |=> !irq_o && reset_mode_o && bus_idle_o && !wb_ack_o; endproperty
  property p_idle; !$past(rst_i) |-> bus_idle_o == !($past(eng_i.transmitting) || $past(eng_i.receiving)); endproperty
  property p_txbuf; txbuf_we_o |-> $past(txbuf_wr_i); endproperty
  property p_start; tx_start_o |-> $past(cmd_tx) || $past(cmd_tx, 2); endproperty
  property p_release; rx_release_o |-> $past(cmd_rl) || $past(cmd_rl, 2); endproperty
  property p_mode_fall; $fell(reset_mode_o) |-> $past(mode_0) || $past(mode_0, 2); endproperty
  property p_irq; wb_ack_o && !wb_we_i && wb_adr_i == 8'h0C && wb_dat_o[7:0] != 8'h00 |-> irq_o; endproperty
  property p_cmd_zero; wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |-> wb_dat_o == 32'h0000_0000; endproperty
  a_answer: assert property (p_answer) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_reset: assert property (p_reset) else $error("outputs wrong after reset");
  a_idle: assert property (p_idle) else $error("bus idle wrong");
  a_txbuf: assert property (p_txbuf) else $error("buffer write without attempt");
  a_start: assert property (p_start) else $error("transmit start without request");
  a_release: assert property (p_release) else $error("release without command");
  a_mode_fall: assert property (p_mode_fall) else $error("reset mode left alone");
  a_irq: assert property (p_irq) else $error("flags set but request low");
  a_cmd_zero: assert property (p_cmd_zero) else $error("command read not zero");
  c_start: cover property (tx_start_o);
  c_release: cover property (rx_release_o);
  c_mode: cover property ($fell(reset_mode_o));
endmodule
bind csi_status_irq csi_status_irq_properties chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .eng_i(eng_i), .txbuf_wr_i(txbuf_wr_i), .txbuf_we_o(txbuf_we_o),
  .tx_start_o(tx_start_o), .rx_release_o(rx_release_o), .reset_mode_o(reset_mode_o),
  .bus_idle_o(bus_idle_o), .irq_o(irq_o));

/* File: dv/csi_engine_model.sv */
// Protocol engine and receive FIFO model facing the flag block.
// Assumes the bench requests events one cycle at a time.
`timescale 1ns/1ps
module csi_engine_model (
  input  wire logic               clk_i,        // System clock
  input  wire logic               rst_i,        // Synchronous reset
  input  wire logic [12:0]        ev_i,         // Requested events
  input  wire logic [7:0]         len_i,        // Bytes of stored frame
  input  wire logic               rx_release_i, // Release from block
  output csi_pkg::csi_engine_t    eng_o,        // Engine events
  output csi_pkg::csi_fifo_t      fifo_o        // FIFO state
);
  import csi_pkg::*;
  logic [7:0] sizes[$]; // Bytes of each held message
  // Registered events and FIFO bookkeeping
  always @(posedge clk_i) begin
    eng_o <= csi_engine_t'(ev_i);
    if (rst_i) begin
      sizes.delete();
      fifo_o <= '0;
    end else if (ev_i[2] && !ev_i[1] && len_i != 8'h00) begin
      sizes.push_back(len_i);
      fifo_o.msg_count  <= fifo_o.msg_count + 6'h01;
      fifo_o.byte_count <= fifo_o.byte_count + len_i;
    end else if (rx_release_i && sizes.size() > 0) begin
      fifo_o.msg_count  <= fifo_o.msg_count - 6'h01;
      fifo_o.byte_count <= fifo_o.byte_count - sizes.pop_front();
    end
  end
endmodule

/* File: dv/testbench.sv */
// Bench for the CAN status and interrupt flag block over Wishbone.
// Assumes the engine model drives events and FIFO state.
`timescale 1ns/1ps
module testbench;
  import csi_pkg::*;
  localparam logic [12:0] E_TXINC = 13'h1000, E_TXOK = 13'h0400, E_RXOK = 13'h0200, E_BERR = 13'h0100;
  localparam logic [12:0] E_ARB = 13'h0080, E_FREE = 13'h0040, E_ACT = 13'h0020, E_FV = 13'h0004;
  localparam logic [12:0] E_NR = 13'h0002, E_HP = 13'h0001;
  localparam logic [7:0] A_MODE = 8'h00, A_CMD = 8'h04, A_ST = 8'h08, A_IRQ = 8'h0C, A_EN = 8'h10;
  localparam logic [7:0] A_LVL = 8'h14, A_ARB = 8'h2C, A_ECC = 8'h30, A_TXE = 8'h3C;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, txwr = 1'b0;
  logic [7:0]  adr = 8'h00, len = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
  logic [12:0] ev = 13'h0000;
  logic        ack, txwe, txst, rel, rmode, idle, irq;
  csi_engine_t eng;
  csi_fifo_t   fifo;
  int          miscompares = 0, tests_run = 0, we_cnt = 0, st_cnt = 0;
  always #12.5 clk_i = ~clk_i;
  // Count accepted buffer writes
  always @(posedge clk_i) if (txwe === 1'b1) we_cnt <= we_cnt + 1;
  // Count transmit start pulses
  always @(posedge clk_i) if (txst === 1'b1) st_cnt <= st_cnt + 1;
  csi_status_irq dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .eng_i(eng),
    .fifo_i(fifo), .txbuf_wr_i(txwr), .txbuf_we_o(txwe), .tx_start_o(txst), .rx_release_o(rel),
    .reset_mode_o(rmode), .bus_idle_o(idle), .irq_o(irq));
  csi_engine_model eng_u (.clk_i(clk_i), .rst_i(rst_i), .ev_i(ev), .len_i(len), .rx_release_i(rel),
    .eng_o(eng), .fifo_o(fifo));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One classic cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk_i);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20) begin
      check("ack_timeout", 32'h1, 32'h0);
      print_verdict();
    end
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    bus(1'b0, a, 32'h0);
    check(name, {24'h0, exp}, rdat & {24'hFF_FFFF, m});
  endtask
  // Event pulses, then settle time for flags
  task automatic pulse(input logic [12:0] v, input int n, input logic [7:0] l);
    repeat (n) begin
      @(posedge clk_i);
      ev <= v;
      len <= l;
      @(posedge clk_i);
      ev <= 13'h0000;
      len <= 8'h00;
    end
    repeat (3) @(posedge clk_i);
  endtask
  task automatic txw();
    @(posedge clk_i);
    txwr <= 1'b1;
    @(posedge clk_i);
    txwr <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("irq_rst", A_IRQ, 8'h00, 8'hFF);
    rd_chk("mode_rst", A_MODE, 8'h01, 8'h01);
    rd_chk("st_rst", A_ST, 8'h04, 8'hFF);
    rd_chk("unmapped", 8'h40, 8'h00, 8'hFF);
    bus(1'b1, A_EN, 32'hFF);
    bus(1'b1, A_MODE, 32'h00);
    bus(1'b1, A_LVL, 32'h05);
    pulse(E_BERR | E_ARB, 2, 8'h00);
    rd_chk("berr_arb", A_IRQ, 8'hC0, 8'hFF);
    pulse(E_BERR | E_ARB, 1, 8'h00);
    rd_chk("locked", A_IRQ, 8'h00, 8'hFF);
    bus(1'b0, A_ECC, 32'h0);
    bus(1'b0, A_ARB, 32'h0);
    pulse(E_BERR, 1, 8'h00);
    rd_chk("unlocked", A_IRQ, 8'h80, 8'hFF);
    bus(1'b1, A_MODE, 32'h10);
    pulse(E_ACT, 1, 8'h00);
    rd_chk("wake", A_IRQ, 8'h10, 8'hFF);
    bus(1'b1, A_MODE, 32'h00);
    pulse(E_TXINC, 12, 8'h00);
    rd_chk("txerr96", A_TXE, 8'h60, 8'hFF);
    rd_chk("warn", A_ST, 8'h40, 8'hC0);
    rd_chk("err_irq", A_IRQ, 8'h04, 8'hFF);
    pulse(E_TXINC, 4, 8'h00);
    rd_chk("passive", A_IRQ, 8'h20, 8'hFF);
    bus(1'b0, A_ECC, 32'h0);
    pulse(E_TXINC, 16, 8'h00);
    rd_chk("busoff", A_ST, 8'hC0, 8'hC0);
    rd_chk("rstmode", A_MODE, 8'h01, 8'h01);
    check("rmode_o", 32'h1, {31'h0, rmode});
    rd_chk("txerr127", A_TXE, 8'h7F, 8'hFF);
    rd_chk("busoff_irq", A_IRQ, 8'h84, 8'h84);
    pulse(E_FREE, 4, 8'h00);
    rd_chk("held", A_TXE, 8'h7F, 8'hFF);
    bus(1'b1, A_MODE, 32'h00);
    pulse(E_FREE, 64, 8'h00);
    rd_chk("recov", A_TXE, 8'h3F, 8'hFF);
    rd_chk("still_off", A_ST, 8'h80, 8'h80);
    pulse(E_FREE, 64, 8'h00);
    rd_chk("bus_on", A_ST, 8'h00, 8'hC0);
    rd_chk("txerr0", A_TXE, 8'h00, 8'hFF);
    rd_chk("on_irq", A_IRQ, 8'h04, 8'h04);
    bus(1'b1, A_CMD, 32'h01);
    pulse(E_TXOK, 1, 8'h00);
    rd_chk("tx_done", A_ST, 8'h0C, 8'h0C);
    rd_chk("tx_irq", A_IRQ, 8'h02, 8'h02);
    bus(1'b1, A_CMD, 32'h10);
    rd_chk("tx_pend", A_ST, 8'h00, 8'h0C);
    check("tx_start", 32'd2, st_cnt);
    txw();
    check("txbuf_drop", 32'd0, we_cnt);
    pulse(E_TXOK, 1, 8'h00);
    txw();
    check("txbuf_ok", 32'd1, we_cnt);
    pulse(E_NR, 1, 8'h00);
    rd_chk("no_ovr", A_ST, 8'h00, 8'h02);
    pulse(E_FV | E_NR, 1, 8'h00);
    rd_chk("ovr", A_ST, 8'h02, 8'h02);
    check("irq_high", 32'h1, {31'h0, irq});
    rd_chk("ovr_irq", A_IRQ, 8'h08, 8'h08);
    pulse(E_FV | E_NR, 1, 8'h00);
    rd_chk("ovr_once", A_IRQ, 8'h00, 8'h08);
    bus(1'b1, A_CMD, 32'h08);
    pulse(E_FV | E_NR, 1, 8'h00);
    rd_chk("ovr_again", A_IRQ, 8'h08, 8'h08);
    pulse(E_FV | E_RXOK | E_HP, 1, 8'h02);
    rd_chk("rx_prio", A_IRQ, 8'h01, 8'h01);
    rd_chk("rx_keep", A_IRQ, 8'h01, 8'hFF);
    pulse(E_FV | E_RXOK, 1, 8'h08);
    bus(1'b1, A_CMD, 32'h04);
    pulse(13'h0000, 0, 8'h00);
    rd_chk("rx_again", A_IRQ, 8'h01, 8'h01);
    rd_chk("rx_full", A_ST, 8'h01, 8'h01);
    bus(1'b1, A_CMD, 32'h04);
    pulse(13'h0000, 0, 8'h00);
    rd_chk("rx_clear", A_IRQ, 8'h00, 8'hFF);
    rd_chk("rx_empty", A_ST, 8'h00, 8'h01);
    // Engine busy in both directions
    @(posedge clk_i);
    ev <= 13'h0018;
    repeat (3) @(posedge clk_i);
    check("busy", 32'h0, {31'h0, idle});
    rd_chk("ts_rs", A_ST, 8'h30, 8'h30);
    ev <= 13'h0000;
    pulse(13'h0000, 0, 8'h00);
    check("idle", 32'h1, {31'h0, idle});
    pulse(13'h0000, 0, 8'h00);
    check("irq_low", 32'h0, {31'h0, irq});
    print_verdict();
  end
endmodule
